// ### adc_power_mode_control.sv
// Purpose: Power-mode control of a two-converter ADC: manual off, auto modes, start-up delay.
// Assumes: Runs on the ADC clock; scan requests and busy flags come from the scan sequencer.
// Notes: The start-up delay is counted by a small timer instance.
`timescale 1ns/1ps
// Functional notes
// R1 - Each converter and reference can power down
// R2 - Software keeps reference and one converter on
// R3 - Manual off forces; automatic control also exists
// R4 - Idle means no scan on either converter
// R5 - Standby current only at standby clock
// R6 - Current mode changes only while idle
// R7 - Both converters share one current mode
// R8 - Auto modes delay each idle-to-active start
// R9 - Auto standby bit 15, ignored under powerdown
// R10 - Standby idle: standby clock, standby current
// R11 - Scan start: conversion clock, then delay
// R12 - Back to idle: standby clock again
// R13 - B status sets at once, clears after delay
// R14 - Auto powerdown: B status shows present power
// R15 - Reference status bit 12 shows its power
// R16 - Manual off immediate; clear gives steady/on-demand
// R17 - Auto powerdown powers converters only for scans
// R18 - Delay field bits 9..4, resets to 13
// R19 - Mode enabled mid-scan waits for idle
// R20 - Bits 14 and 13 read zero
module adc_power_mode_control (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [adc_power_pkg::ADDR_W-1:0] i_addr,
    input wire logic [adc_power_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [adc_power_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_scan_req,
    input wire logic [1:0] i_scan_uses,
    input wire logic i_conv_a_busy,
    input wire logic i_conv_b_busy,
    output logic o_scan_go,
    output logic o_conv_a_power_on,
    output logic o_conv_b_power_on,
    output logic o_vref_power_on,
    output logic o_standby_clk_sel,
    output logic o_standby_current
);
    import adc_power_pkg::*;

    logic conv_a_manual_off_ff;
    logic conv_b_manual_off_ff;
    logic vref_manual_off_ff;
    logic auto_powerdown_enable_ff;
    logic auto_standby_enable_ff;
    logic [DLY_W-1:0] powerup_delay_count_ff;
    logic conv_a_power_state_ff;
    logic conv_b_power_state_ff;
    pwr_state_e state_ff;
    pwr_state_e nxt_state;
    logic [1:0] need_ff;
    logic timer_start;
    logic timer_done;
    logic [1:0] manual_settle;
    logic [1:0] manual_off;
    logic [1:0] settle_done;
    logic module_idle;
    logic auto_sb;
    logic auto_any;
    logic reg_hit_wr;
    logic [1:0] conv_on;
    logic vref_on;
    logic [DLY_W-1:0] timer_count;

    // Address decode shared by the write and read paths.
    function automatic logic hits_ctrl(input logic [ADDR_W-1:0] a);
        return a == ADC_POWER_CONTROL_OFS;
    endfunction : hits_ctrl

    // Idle when no converter has a scan in progress and no scan is being started.
    assign module_idle = !i_conv_a_busy && !i_conv_b_busy && (state_ff == ST_IDLE); // R4
    assign auto_sb = auto_standby_enable_ff && !auto_powerdown_enable_ff; // R9
    assign auto_any = auto_sb || auto_powerdown_enable_ff; // R8
    assign reg_hit_wr = i_wr && hits_ctrl(i_addr);
    assign manual_off = {conv_b_manual_off_ff, conv_a_manual_off_ff};

    // Register writes; status bits and reserved bits 14..13 are not stored.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            conv_a_manual_off_ff <= MANUAL_OFF_RESET[0];
            conv_b_manual_off_ff <= MANUAL_OFF_RESET[1];
            vref_manual_off_ff <= MANUAL_OFF_RESET[2];
            auto_powerdown_enable_ff <= 1'b0;
            auto_standby_enable_ff <= 1'b0;
            powerup_delay_count_ff <= DLY_RESET; // R18
        end else if (reg_hit_wr) begin
            conv_a_manual_off_ff <= i_wdata[BIT_CONV_A_MANUAL_OFF]; // R3
            conv_b_manual_off_ff <= i_wdata[BIT_CONV_B_MANUAL_OFF]; // R3
            vref_manual_off_ff <= i_wdata[BIT_VREF_MANUAL_OFF]; // R3
            auto_powerdown_enable_ff <= i_wdata[BIT_AUTO_POWERDOWN];
            auto_standby_enable_ff <= i_wdata[BIT_AUTO_STANDBY]; // R9
            powerup_delay_count_ff <= i_wdata[DLY_MSB:DLY_LSB]; // R18
        end
    end

    // Wake sequencing: scans in auto modes wait the programmed delay first.
    always_comb begin
        nxt_state = state_ff;
        timer_start = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (i_scan_req && !i_conv_a_busy && !i_conv_b_busy) begin
                    if (auto_any) begin
                        nxt_state = ST_WAKE; // R8
                        timer_start = 1'b1; // R11
                    end else begin
                        nxt_state = ST_RUN;
                    end
                end
            end
            ST_WAKE: begin
                if (timer_done) begin
                    nxt_state = ST_RUN; // R11
                end
            end
            ST_RUN: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Manual settle timer shares the counter when a power-down is released.
    assign manual_settle = {conv_b_manual_off_ff && reg_hit_wr
                               && !i_wdata[BIT_CONV_B_MANUAL_OFF],
                           conv_a_manual_off_ff && reg_hit_wr
                               && !i_wdata[BIT_CONV_A_MANUAL_OFF]};

    // A release written together with a new delay must count the new delay, not the old.
    assign timer_count = reg_hit_wr ? i_wdata[DLY_MSB:DLY_LSB] : powerup_delay_count_ff; // R13

    powerup_timer #(
        .WIDTH(DLY_W)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(timer_start || (|manual_settle)),
        .i_count(timer_count),
        .o_done(timer_done)
    );

    // State register and the set of converters the pending scan needs.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
            need_ff <= 2'b00;
        end else begin
            state_ff <= nxt_state;
            if (timer_start) begin
                need_ff <= i_scan_uses;
            end else if (module_idle) begin
                need_ff <= 2'b00;
            end
        end
    end

    // Converter power: manual off wins; auto powerdown powers only needed units.
    generate
        for (genvar gi = 0; gi < 2; gi++) begin : g_conv
            logic busy;
            assign busy = (gi == 0) ? i_conv_a_busy : i_conv_b_busy;
            assign conv_on[gi] = !manual_off[gi] && (!auto_powerdown_enable_ff // R16
                || need_ff[gi] || busy); // R17
            assign settle_done[gi] = timer_done && !manual_off[gi];
        end
    endgenerate

    // Reference runs when not forced off or while any converter runs.
    assign vref_on = !vref_manual_off_ff || (|conv_on); // R1

    // Power status: set at once on manual off; cleared after the settle delay, or under auto powerdown once the converter is powered.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            conv_a_power_state_ff <= 1'b1;
            conv_b_power_state_ff <= 1'b1;
        end else if (auto_powerdown_enable_ff) begin
            conv_a_power_state_ff <= !conv_on[0];
            conv_b_power_state_ff <= !conv_on[1]; // R14
        end else begin
            if (manual_off[0]) begin
                conv_a_power_state_ff <= 1'b1;
            end else if (settle_done[0]) begin
                conv_a_power_state_ff <= 1'b0;
            end
            if (manual_off[1]) begin
                conv_b_power_state_ff <= 1'b1; // R13
            end else if (settle_done[1]) begin
                conv_b_power_state_ff <= 1'b0; // R13
            end
        end
    end

    // Physical controls; clock and current change only while idle so a scan is never cut.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_conv_a_power_on <= 1'b0;
            o_conv_b_power_on <= 1'b0;
            o_vref_power_on <= 1'b0;
            o_standby_clk_sel <= 1'b0;
            o_standby_current <= 1'b0;
            o_scan_go <= 1'b0;
        end else begin
            o_conv_a_power_on <= conv_on[0]; // R1
            o_conv_b_power_on <= conv_on[1]; // R1
            o_vref_power_on <= vref_on;
            o_scan_go <= (state_ff == ST_WAKE && timer_done)
                || (state_ff == ST_IDLE && nxt_state == ST_RUN);
            if (timer_start) begin
                o_standby_clk_sel <= 1'b0; // R11
                o_standby_current <= 1'b0; // R7
            end else if (module_idle && nxt_state == ST_IDLE) begin
                o_standby_clk_sel <= auto_sb; // R10 R12 R19
                o_standby_current <= auto_sb; // R5 R6 R7
            end
        end
    end

    // Read path: one cycle of latency, unmapped addresses read zero.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_rd && hits_ctrl(i_addr)) begin
            o_rdata <= '0; // R20
            o_rdata[BIT_AUTO_STANDBY] <= auto_standby_enable_ff;
            o_rdata[BIT_VREF_STATE] <= !vref_on; // R15
            o_rdata[BIT_CONV_B_STATE] <= conv_b_power_state_ff;
            o_rdata[BIT_CONV_A_STATE] <= conv_a_power_state_ff;
            o_rdata[DLY_MSB:DLY_LSB] <= powerup_delay_count_ff;
            o_rdata[BIT_AUTO_POWERDOWN] <= auto_powerdown_enable_ff;
            o_rdata[BIT_VREF_MANUAL_OFF] <= vref_manual_off_ff;
            o_rdata[BIT_CONV_B_MANUAL_OFF] <= conv_b_manual_off_ff;
            o_rdata[BIT_CONV_A_MANUAL_OFF] <= conv_a_manual_off_ff;
        end else begin
            o_rdata <= '0;
        end
    end

    property p_b_status_set;
        @(posedge i_clk) disable iff (i_rst)
        conv_b_manual_off_ff |=> conv_b_power_state_ff;
    endproperty
    a_b_status_set: assert property (p_b_status_set) else $error("B status not set"); // R13

    property p_b_auto;
        @(posedge i_clk) disable iff (i_rst)
        auto_powerdown_enable_ff && $stable(auto_powerdown_enable_ff)
            |=> conv_b_power_state_ff == !$past(conv_on[1]);
    endproperty
    a_b_auto: assert property (p_b_auto) else $error("B status wrong in auto"); // R14

    property p_same_current;
        @(posedge i_clk) disable iff (i_rst)
        o_standby_current == o_standby_clk_sel;
    endproperty
    a_same_current: assert property (p_same_current) else $error("Current and clock differ"); // R7

    property p_no_standby_busy;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_standby_current) |-> $past(module_idle);
    endproperty
    a_no_standby_busy: assert property (p_no_standby_busy) else $error("Standby while busy"); // R6

    property p_wake_clock;
        @(posedge i_clk) disable iff (i_rst)
        timer_start |=> !o_standby_clk_sel && !o_scan_go;
    endproperty
    a_wake_clock: assert property (p_wake_clock) else $error("Wake did not switch clock"); // R11

    property p_pd_wins;
        @(posedge i_clk) disable iff (i_rst)
        auto_powerdown_enable_ff && module_idle && !timer_start |=> !o_standby_clk_sel;
    endproperty
    a_pd_wins: assert property (p_pd_wins) else $error("Standby under auto powerdown"); // R9

    property p_manual_off;
        @(posedge i_clk) disable iff (i_rst)
        conv_a_manual_off_ff |=> !o_conv_a_power_on;
    endproperty
    a_manual_off: assert property (p_manual_off) else $error("Converter A on while off"); // R16

    property p_reserved;
        @(posedge i_clk) disable iff (i_rst)
        o_rdata[14:13] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits nonzero"); // R20

    property p_wake_go;
        @(posedge i_clk) disable iff (i_rst)
        state_ff == ST_WAKE |=> o_scan_go == $past(timer_done);
    endproperty
    a_wake_go: assert property (p_wake_go) else $error("Scan go not tied to delay end"); // R8

    c_wake: cover property (@(posedge i_clk) disable iff (i_rst) timer_start ##[1:70] o_scan_go);
    c_standby: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_standby_clk_sel));
    c_b_clear: cover property (@(posedge i_clk) disable iff (i_rst) $fell(conv_b_power_state_ff));
endmodule : adc_power_mode_control

// ### adc_power_pkg.sv
// Purpose: Constants shared by the converter power-mode control block.
// Assumes: One 16-bit control/status register reached over a plain strobe port.
// Notes: Field positions, reset values and the register offset live here.
package adc_power_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DLY_W = 6;
    localparam logic [ADDR_W-1:0] ADC_POWER_CONTROL_OFS = 4'h0;
    localparam int unsigned BIT_CONV_A_MANUAL_OFF = 0;
    localparam int unsigned BIT_CONV_B_MANUAL_OFF = 1;
    localparam int unsigned BIT_VREF_MANUAL_OFF = 2;
    localparam int unsigned BIT_AUTO_POWERDOWN = 3;
    localparam int unsigned DLY_LSB = 4;
    localparam int unsigned DLY_MSB = 9;
    localparam int unsigned BIT_CONV_A_STATE = 10;
    localparam int unsigned BIT_CONV_B_STATE = 11;
    localparam int unsigned BIT_VREF_STATE = 12;
    localparam int unsigned BIT_AUTO_STANDBY = 15;
    localparam logic [DLY_W-1:0] DLY_RESET = 6'h0D;
    localparam logic [2:0] MANUAL_OFF_RESET = 3'h7;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAKE = 2'b01,
        ST_RUN = 2'b11
    } pwr_state_e;
endpackage : adc_power_pkg

// ### powerup_timer.sv
// Purpose: Counts a programmed number of clocks after a start pulse.
// Assumes: A load of zero completes on the next clock.
// Notes: Done is a registered level until the next start.
`timescale 1ns/1ps
module powerup_timer #(
    parameter int unsigned WIDTH = 6
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_done
);
    logic [WIDTH-1:0] cnt_ff;
    logic busy_ff;

    // Load on start, then count down; done rises when the count is spent.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            o_done <= 1'b0;
        end else if (i_start) begin
            cnt_ff <= i_count;
            busy_ff <= 1'b1;
            o_done <= 1'b0;
        end else if (busy_ff) begin
            if (cnt_ff <= WIDTH'(1)) begin
                busy_ff <= 1'b0;
                o_done <= 1'b1;
            end
            cnt_ff <= (cnt_ff == '0) ? cnt_ff : cnt_ff - WIDTH'(1);
        end
    end
endmodule : powerup_timer

// ### adc_power_mode_control_tb.sv
// Purpose: Self-checking bench for the converter power-mode control block.
// Assumes: Register at offset 0; the bench plays the scan sequencer itself.
// Notes: Expected words are written as hex literals, never read back.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module adc_power_mode_control_tb;
    import adc_power_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic i_scan_req = 1'b0;
    logic [1:0] i_scan_uses = 2'b00;
    logic i_conv_a_busy = 1'b0;
    logic i_conv_b_busy = 1'b0;
    logic o_scan_go, o_conv_a_power_on, o_conv_b_power_on, o_vref_power_on;
    logic o_standby_clk_sel, o_standby_current;
    int errors = 0;
    int total_checks = 0;
    int lat;

    adc_power_mode_control dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scan_req(i_scan_req),
        .i_scan_uses(i_scan_uses), .i_conv_a_busy(i_conv_a_busy),
        .i_conv_b_busy(i_conv_b_busy), .o_scan_go(o_scan_go),
        .o_conv_a_power_on(o_conv_a_power_on), .o_conv_b_power_on(o_conv_b_power_on),
        .o_vref_power_on(o_vref_power_on), .o_standby_clk_sel(o_standby_clk_sel),
        .o_standby_current(o_standby_current)
    );

    // A 100 ns period stands for the 10 MHz converter clock.
    always #50 i_clk = ~i_clk;

    // One write cycle; the strobe drops at the edge that took it.
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe edge, so look there.
    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, exp)
    endtask : rd_reg

    // Waits whole cycles and steps past the edge so registered outputs have settled.
    task automatic cycles(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cycles

    // Raises a scan request and counts edges from the raising edge to the go pulse.
    // Busy rises and the request drops at the edge that closes the go cycle.
    task automatic scan(input logic [1:0] u, output int n);
        @(posedge i_clk);
        i_scan_req <= 1'b1;
        i_scan_uses <= u;
        @(posedge i_clk);
        #1;
        n = 1;
        while (o_scan_go !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        @(posedge i_clk);
        i_scan_req <= 1'b0;
        i_conv_a_busy <= u[0];
        i_conv_b_busy <= u[1];
        #1;
    endtask : scan

    // Ends the scan: both converters go quiet.
    task automatic scan_done();
        @(posedge i_clk);
        i_conv_a_busy <= 1'b0;
        i_conv_b_busy <= 1'b0;
    endtask : scan_done

    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note

    // The single place where the run is judged and stopped.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    // The whole sequence needs under two hundred cycles; three thousand means a hang.
    initial begin
        #(3000 * 100);
        errors++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        cycles(1);
        `CHK({o_conv_a_power_on, o_conv_b_power_on, o_vref_power_on}, 3'b000)
        rd_reg(4'h0, 16'h1cd7);
        note("reset");
        wr_reg(4'h1, 16'h0000);
        rd_reg(4'h1, 16'h0000);
        rd_reg(4'h0, 16'h1cd7);
        note("unmapped");
        wr_reg(4'h0, 16'h7c50);
        rd_reg(4'h0, 16'h0c50);
        cycles(10);
        rd_reg(4'h0, 16'h0050);
        `CHK({o_conv_a_power_on, o_conv_b_power_on, o_vref_power_on}, 3'b111)
        note("reserved and release");
        scan(2'b11, lat);
        `CHK(lat, 1)
        `CHK(o_standby_clk_sel, 1'b0)
        scan_done();
        note("plain scan");
        wr_reg(4'h0, 16'h0052);
        rd_reg(4'h0, 16'h0852);
        `CHK({o_conv_a_power_on, o_conv_b_power_on}, 2'b10)
        wr_reg(4'h0, 16'h0050);
        rd_reg(4'h0, 16'h0850);
        cycles(10);
        rd_reg(4'h0, 16'h0050);
        note("manual off");
        wr_reg(4'h0, 16'h8050);
        cycles(3);
        `CHK({o_standby_clk_sel, o_standby_current}, 2'b11)
        scan(2'b01, lat);
        `CHK(lat, 7)
        `CHK({o_standby_clk_sel, o_standby_current}, 2'b00)
        repeat (4) begin
            cycles(1);
            `CHK({o_standby_clk_sel, o_standby_current}, 2'b00)
        end
        scan_done();
        cycles(3);
        `CHK({o_standby_clk_sel, o_standby_current}, 2'b11)
        note("auto standby");
        wr_reg(4'h0, 16'h8058);
        cycles(3);
        `CHK({o_standby_clk_sel, o_standby_current}, 2'b00)
        `CHK({o_conv_a_power_on, o_conv_b_power_on}, 2'b00)
        rd_reg(4'h0, 16'h8c58);
        scan(2'b10, lat);
        `CHK(lat, 7)
        `CHK({o_conv_a_power_on, o_conv_b_power_on}, 2'b01)
        rd_reg(4'h0, 16'h8458);
        scan_done();
        cycles(3);
        `CHK(o_conv_b_power_on, 1'b0)
        note("auto powerdown");
        wr_reg(4'h0, 16'h0050);
        cycles(10);
        scan(2'b01, lat);
        `CHK(lat, 1)
        wr_reg(4'h0, 16'h8050);
        cycles(2);
        `CHK(o_standby_clk_sel, 1'b0)
        scan_done();
        cycles(3);
        `CHK(o_standby_clk_sel, 1'b1)
        note("mode change mid-scan");
        wr_reg(4'h0, 16'h0057);
        cycles(2);
        `CHK(o_vref_power_on, 1'b0)
        rd_reg(4'h0, 16'h1c57);
        wr_reg(4'h0, 16'h0053);
        cycles(2);
        `CHK(o_vref_power_on, 1'b1)
        rd_reg(4'h0, 16'h0c53);
        note("reference");
        end_of_test();
    end
endmodule : adc_power_mode_control_tb
